// >>> design/acg_top.sv
// Audio clock generation: registers, reference divider, N/CTS
// regeneration, bit clock and word select generation.
// Assumes an Avalon-MM master on the system clock; the pins and the
// VCO and oscillator inputs are asynchronous and resynchronised here.
//
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ns
// How it works
// RULE1 - Word select spans 64 or 32 bit clocks
// RULE2 - Bits 6:5 set master-to-bit clock ratio
// RULE3 - Cleaner reference: VCO /8, /4, /2 or oscillator
// RULE4 - Nonzero clean mode cleans at ratio 1/2/4
// RULE5 - Drive bit makes both pins outputs, generates
// RULE6 - 24-bit CTS from three bytes, low first
// RULE7 - 20-bit N from two bytes plus nibble
// RULE8 - Upper nibble sets loop filter feedback shift
// RULE9 - Status reports input and output fill levels
// RULE10 - Software writes all N/CTS bytes before use
module acg_top #(
	parameter int EST_W = 16
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic serial_pll_vco_clock_i,
	input wire logic always_on_oscillator_i,
	input wire logic bit_clk_i,
	input wire logic word_sel_i,
	output logic bit_clk_o,
	output logic bit_clk_oe_o,
	output logic word_sel_o,
	output logic word_sel_oe_o,
	output logic master_clk_o
);
	acg_clean_if cif ();

	// True when the byte address is aligned and hits the given index
	function automatic logic is_idx(input logic [7:0] addr,
		input logic [5:0] idx);
		is_idx = addr[1:0] == 2'h0 && addr[7:2] == idx;
	endfunction

	acg_pkg::acg_bus_e bus_reg, bus_next;
	logic wait_reg, wait_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [7:0] ctrl_reg, ctrl_next;
	logic [23:0] cts_reg, cts_next;
	logic [19:0] n_reg, n_next;
	logic [3:0] shift_reg, shift_next;
	logic [7:0] rd_byte;
	logic wr_ok;

	// Register read decode
	always_comb
	begin
		if (is_idx(avs_address_i, acg_pkg::IDX_RATIO_CTRL))
			rd_byte = ctrl_reg;
		else if (is_idx(avs_address_i, acg_pkg::IDX_CTS0))
			rd_byte = cts_reg[7:0];
		else if (is_idx(avs_address_i, acg_pkg::IDX_CTS1))
			rd_byte = cts_reg[15:8];
		else if (is_idx(avs_address_i, acg_pkg::IDX_CTS2))
			rd_byte = cts_reg[23:16];
		else if (is_idx(avs_address_i, acg_pkg::IDX_N0))
			rd_byte = n_reg[7:0];
		else if (is_idx(avs_address_i, acg_pkg::IDX_N1))
			rd_byte = n_reg[15:8];
		else if (is_idx(avs_address_i, acg_pkg::IDX_N2_SHIFT))
			rd_byte = {shift_reg, n_reg[19:16]};
		else if (is_idx(avs_address_i, acg_pkg::IDX_FIFO_STS))
			rd_byte = {2'h0, cif.in_fill, cif.out_fill}; // [RULE9]
		else
			rd_byte = 8'h00; // Unmapped reads return zero
	end

	// Bus slave: one wait cycle, then the access completes
	always_comb
	begin
		bus_next = bus_reg;
		wait_next = 1'b1;
		rdata_next = rdata_reg;
		ctrl_next = ctrl_reg;
		cts_next = cts_reg;
		n_next = n_reg;
		shift_next = shift_reg;
		wr_ok = avs_write_i && avs_byteenable_i[0];
		case (bus_reg)
			acg_pkg::ACG_BUS_IDLE:
			begin
				if (avs_read_i || avs_write_i)
				begin
					bus_next = acg_pkg::ACG_BUS_ACK;
					wait_next = 1'b0;
					if (avs_read_i)
						rdata_next = {24'h00_0000, rd_byte};
				end
			end
			default:
			begin
				bus_next = acg_pkg::ACG_BUS_IDLE;
				if (wr_ok && is_idx(avs_address_i, acg_pkg::IDX_RATIO_CTRL))
					ctrl_next = avs_writedata_i[7:0];
				else if (wr_ok && is_idx(avs_address_i, acg_pkg::IDX_CTS0))
					cts_next[7:0] = avs_writedata_i[7:0]; // [RULE6]
				else if (wr_ok && is_idx(avs_address_i, acg_pkg::IDX_CTS1))
					cts_next[15:8] = avs_writedata_i[7:0]; // [RULE6]
				else if (wr_ok && is_idx(avs_address_i, acg_pkg::IDX_CTS2))
					cts_next[23:16] = avs_writedata_i[7:0]; // [RULE6]
				else if (wr_ok && is_idx(avs_address_i, acg_pkg::IDX_N0))
					n_next[7:0] = avs_writedata_i[7:0]; // [RULE7]
				else if (wr_ok && is_idx(avs_address_i, acg_pkg::IDX_N1))
					n_next[15:8] = avs_writedata_i[7:0]; // [RULE7]
				else if (wr_ok && is_idx(avs_address_i, acg_pkg::IDX_N2_SHIFT))
				begin
					n_next[19:16] = avs_writedata_i[3:0]; // [RULE7]
					shift_next = avs_writedata_i[7:4]; // [RULE8]
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			bus_reg <= acg_pkg::ACG_BUS_IDLE;
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
			ctrl_reg <= acg_pkg::REG_RESET;
			cts_reg <= 24'h00_0000;
			n_reg <= 20'h0_0000;
			shift_reg <= 4'h0;
		end
		else
		begin
			bus_reg <= bus_next;
			wait_reg <= wait_next;
			rdata_reg <= rdata_next;
			ctrl_reg <= ctrl_next;
			cts_reg <= cts_next;
			n_reg <= n_next;
			shift_reg <= shift_next;
		end
	end

	// Three-stage synchronisers for vco, oscillator, bit clock, word select
	logic [3:0] pin_raw;
	logic [3:0] s1_reg, s2_reg, s3_reg, lvl_reg, rise;
	assign pin_raw = {word_sel_i, bit_clk_i, always_on_oscillator_i,
		serial_pll_vco_clock_i};
	for (genvar g = 0; g < 4; g++)
	begin : g_sync
		always_ff @(posedge clk_sys_i)
		begin
			if (srst_i)
			begin
				s1_reg[g] <= 1'b0;
				s2_reg[g] <= 1'b0;
				s3_reg[g] <= 1'b0;
				lvl_reg[g] <= 1'b0;
			end
			else
			begin
				s1_reg[g] <= pin_raw[g];
				s2_reg[g] <= s1_reg[g];
				s3_reg[g] <= s2_reg[g];
				if (s2_reg[g] == s3_reg[g])
					lvl_reg[g] <= s2_reg[g];
			end
		end
		// A change counts only once stages two and three agree
		assign rise[g] = s2_reg[g] && s3_reg[g] && !lvl_reg[g];
	end

	logic vco_rise, aon_rise, bit_rise, frame_edge;
	logic master;
	assign vco_rise = rise[0];
	assign aon_rise = rise[1];
	assign bit_rise = rise[2];
	assign frame_edge = s2_reg[3] == s3_reg[3] && s2_reg[3] != lvl_reg[3];
	assign master = ctrl_reg[acg_pkg::DRIVE_BIT];

	// Reference divider and N/CTS regeneration
	logic [2:0] vdiv_reg, vdiv_next;
	logic [23:0] acc_reg, acc_next;
	logic [24:0] sum;
	logic ref_reg, ref_next, src_reg, src_next, regen_tick, regen_on;
	always_comb
	begin
		vdiv_next = vco_rise ? vdiv_reg + 3'h1 : vdiv_reg;
		case (ctrl_reg[acg_pkg::REFDIV_LSB +: 2]) // [RULE3]
			2'h0: ref_next = vco_rise && vdiv_reg == 3'h7;
			2'h1: ref_next = vco_rise && vdiv_reg[1:0] == 2'h3;
			2'h2: ref_next = vco_rise && vdiv_reg[0];
			default: ref_next = aon_rise;
		endcase
		// Both values nonzero enable regeneration [RULE6] [RULE7]
		regen_on = cts_reg != 24'h00_0000 && n_reg != 20'h0_0000;
		acc_next = acc_reg;
		regen_tick = 1'b0;
		sum = {1'b0, acc_reg} + {5'h00, n_reg};
		// Output rate is VCO * N / CTS; N above CTS saturates at VCO rate
		if (!regen_on)
			acc_next = 24'h00_0000;
		else if (vco_rise)
		begin
			acc_next = sum[23:0];
			if (sum >= {1'b0, cts_reg})
			begin
				acc_next = 24'(sum - {1'b0, cts_reg});
				regen_tick = 1'b1;
			end
			// A stale phase from older bytes is dropped, not slowly drained
			if (acc_next >= cts_reg)
				acc_next = 24'h00_0000;
		end
		// Received bit clock when receiving; regenerated clock when driving, or the VCO tick while regeneration is off
		if (master)
			src_next = regen_on ? regen_tick : vco_rise; // [RULE5]
		else
			src_next = bit_rise;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			vdiv_reg <= 3'h0;
			acc_reg <= 24'h00_0000;
			ref_reg <= 1'b0;
			src_reg <= 1'b0;
		end
		else
		begin
			vdiv_reg <= vdiv_next;
			acc_reg <= acc_next;
			ref_reg <= ref_next;
			src_reg <= src_next;
		end
	end

	assign cif.in_tick = src_reg;
	assign cif.ref_tick = ref_reg;
	assign cif.mode = ctrl_reg[acg_pkg::CLEAN_LSB +: 2];
	assign cif.shift = shift_reg;
	assign cif.take = cif.out_fill != 3'h0;

	acg_cleaner #(.EST_W(EST_W)) u_cleaner (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.ci(cif.cleaner)
	);

	// Clock generation: each cleaned tick is one master clock half period
	logic [3:0] mdiv;
	logic [5:0] half_frame;
	logic [3:0] hcnt_reg, hcnt_next;
	logic [5:0] bcnt_reg, bcnt_next;
	logic mclk_reg, mclk_next, bclk_reg, bclk_next, wsel_reg, wsel_next;
	logic oe_reg;
	always_comb
	begin
		case (ctrl_reg[acg_pkg::MCLK_LSB +: 2]) // [RULE2]
			2'h0: mdiv = acg_pkg::MDIV_00;
			2'h1: mdiv = acg_pkg::MDIV_01;
			2'h2: mdiv = acg_pkg::MDIV_10;
			default: mdiv = acg_pkg::MDIV_11;
		endcase
		half_frame = ctrl_reg[acg_pkg::FRAME_BIT] ? acg_pkg::HALF_FRAME_32
			: acg_pkg::HALF_FRAME_64; // [RULE1]
		hcnt_next = hcnt_reg;
		bcnt_next = bcnt_reg;
		mclk_next = mclk_reg;
		bclk_next = bclk_reg;
		wsel_next = wsel_reg;
		if (!master)
		begin
			// Generators idle; a received frame edge realigns the count
			hcnt_next = 4'h0;
			mclk_next = 1'b0;
			bclk_next = 1'b0;
			wsel_next = 1'b0;
			if (frame_edge)
				bcnt_next = 6'h00;
		end
		else if (cif.take)
		begin
			mclk_next = !mclk_reg;
			hcnt_next = hcnt_reg + 4'h1;
			if (hcnt_reg >= mdiv - 4'h1)
			begin
				hcnt_next = 4'h0;
				bclk_next = !bclk_reg; // [RULE2]
				if (bclk_reg)
				begin
					bcnt_next = bcnt_reg + 6'h01;
					if (bcnt_reg >= half_frame - 6'h01)
					begin
						bcnt_next = 6'h00;
						wsel_next = !wsel_reg; // [RULE1]
					end
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			hcnt_reg <= 4'h0;
			bcnt_reg <= 6'h00;
			mclk_reg <= 1'b0;
			bclk_reg <= 1'b0;
			wsel_reg <= 1'b0;
			oe_reg <= 1'b0;
		end
		else
		begin
			hcnt_reg <= hcnt_next;
			bcnt_reg <= bcnt_next;
			mclk_reg <= mclk_next;
			bclk_reg <= bclk_next;
			wsel_reg <= wsel_next;
			oe_reg <= master; // Pins driven only while driving is set [RULE5]
		end
	end

	assign avs_readdata_o = rdata_reg;
	assign avs_waitrequest_o = wait_reg;
	assign bit_clk_o = bclk_reg;
	assign bit_clk_oe_o = oe_reg;
	assign word_sel_o = wsel_reg;
	assign word_sel_oe_o = oe_reg;
	assign master_clk_o = mclk_reg;

	sequence s_wr_cts2;
		avs_write_i && avs_byteenable_i[0] && !avs_waitrequest_o
			&& is_idx(avs_address_i, acg_pkg::IDX_CTS2);
	endsequence
	sequence s_rd_sts;
		avs_read_i && avs_waitrequest_o
			&& is_idx(avs_address_i, acg_pkg::IDX_FIFO_STS);
	endsequence

	AST_CTS_HIGH: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE6]
		s_wr_cts2 |=> cts_reg[23:16] == $past(avs_writedata_i[7:0])
			&& cts_reg[15:0] == $past(cts_reg[15:0]))
		else $error("high timestamp byte not stored alone");
	AST_STATUS: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE9]
		s_rd_sts |=> avs_readdata_o[5:0] == $past({cif.in_fill, cif.out_fill})
			&& !avs_waitrequest_o)
		else $error("status read does not show the fill levels");
	AST_PIN_DIR: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE5]
		!master [*2] |-> !bit_clk_oe_o && !word_sel_oe_o && !bit_clk_o)
		else $error("pins driven while receiving");
	AST_FRAME: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE1]
		$changed(word_sel_o) && master && $past(master)
		|-> $past(bcnt_reg) == half_frame - 6'h01)
		else $error("word select toggled off the frame boundary");
	AST_MCLK_RATIO: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE2]
		master && $changed(bit_clk_o) && $past(master)
		|-> $past(hcnt_reg) == mdiv - 4'h1 && $changed(master_clk_o))
		else $error("bit clock toggled off its master clock count");
	AST_REF_AON: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE3]
		ctrl_reg[acg_pkg::REFDIV_LSB +: 2] == 2'h3 && aon_rise |=> ref_reg)
		else $error("oscillator tick did not reach the reference");
	AST_REGEN_OFF: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE7]
		master && n_reg == 20'h0_0000 && vco_rise |=> src_reg)
		else $error("zero N did not fall back to the VCO tick");
	AST_WAIT_ONE: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("wait request low for more than one cycle");
endmodule

// >>> include/acg_pkg.sv
// Constants shared by the audio clock generation block and its cleaner.
// Assumes a 25 MHz system clock and byte-wide registers on 32-bit words.
package acg_pkg;
	// Register indices; the byte address is four times the index
	localparam logic [5:0] IDX_RATIO_CTRL = 6'h30;
	localparam logic [5:0] IDX_CTS0 = 6'h31;
	localparam logic [5:0] IDX_CTS1 = 6'h32;
	localparam logic [5:0] IDX_CTS2 = 6'h33;
	localparam logic [5:0] IDX_N0 = 6'h34;
	localparam logic [5:0] IDX_N1 = 6'h35;
	localparam logic [5:0] IDX_N2_SHIFT = 6'h36;
	localparam logic [5:0] IDX_FIFO_STS = 6'h37;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Field positions in the ratio control, N2/shift and FIFO status registers
	localparam int FRAME_BIT = 7;
	localparam int MCLK_LSB = 5;
	localparam int REFDIV_LSB = 3;
	localparam int CLEAN_LSB = 1;
	localparam int DRIVE_BIT = 0;
	localparam int SHIFT_LSB = 4;
	localparam int IN_FILL_LSB = 3;
	localparam int OUT_FILL_LSB = 0;
	// Bit clock periods per word select half period
	localparam logic [5:0] HALF_FRAME_64 = 6'h20;
	localparam logic [5:0] HALF_FRAME_32 = 6'h10;
	// Master clock half periods per bit clock half period, by code, and the FIFO fill limit
	localparam logic [3:0] MDIV_00 = 4'h4;
	localparam logic [3:0] MDIV_01 = 4'h2;
	localparam logic [3:0] MDIV_10 = 4'h1;
	localparam logic [3:0] MDIV_11 = 4'h8;
	localparam logic [2:0] FILL_MAX = 3'h7;
	// Bus answer state, Gray ordered
	typedef enum logic [0:0] {
		ACG_BUS_IDLE = 1'b0,
		ACG_BUS_ACK = 1'b1
	} acg_bus_e;
endpackage

// >>> include/acg_clean_if.sv
// Signals between the control logic and the clock cleaner.
// Assumes both ends run on the system clock.
`timescale 1ns/1ns
interface acg_clean_if;
	logic in_tick;
	logic ref_tick;
	logic [1:0] mode;
	logic [3:0] shift;
	logic take;
	logic [2:0] in_fill;
	logic [2:0] out_fill;
	modport cleaner (input in_tick, ref_tick, mode, shift, take,
		output in_fill, out_fill);
	modport ctrl (output in_tick, ref_tick, mode, shift, take,
		input in_fill, out_fill);
endinterface

// >>> design/acg_cleaner.sv
// Digital audio clock cleaner: period tracker with shift loop filter.
// Assumes one-cycle tick pulses on the system clock from the control logic.
`timescale 1ns/1ns
module acg_cleaner #(
	parameter int EST_W = 16
) (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	acg_clean_if.cleaner ci
);
	logic [EST_W-1:0] meas_reg, meas_next, est_reg, est_next;
	logic [EST_W-1:0] nco_reg, nco_next, target;
	logic [1:0] sub_reg, sub_next, sub_last;
	logic [2:0] in_reg, in_next, out_reg, out_next;
	logic signed [EST_W:0] diff;
	logic emit, use_in;

	if (EST_W < 4 || EST_W > 24)
		$error("acg_cleaner: EST_W must lie in 4..24");

	// Period tracking, numerically controlled output and fill counters
	always_comb
	begin
		meas_next = meas_reg;
		est_next = est_reg;
		nco_next = nco_reg;
		sub_next = sub_reg;
		emit = 1'b0;
		use_in = 1'b0;
		diff = $signed({1'b0, meas_reg}) - $signed({1'b0, est_reg});
		sub_last = 2'((4'h1 << (ci.mode - 2'h1)) - 4'h1);
		target = est_reg >> (ci.mode - 2'h1);
		if (ci.ref_tick)
			meas_next = meas_reg + 1'b1;
		if (ci.in_tick)
		begin
			// Feedback divided by two to the filter shift [RULE8]
			est_next = EST_W'($signed({1'b0, est_reg}) + (diff >>> ci.shift));
			// A reference tick in this cycle already belongs to the new period
			meas_next = EST_W'(ci.ref_tick);
		end
		if (ci.mode == 2'h0)
		begin
			emit = ci.in_tick; // Cleaning off passes the ticks through [RULE4]
			nco_next = '0;
			sub_next = 2'h0;
		end
		else if (ci.ref_tick)
		begin
			nco_next = nco_reg + 1'b1;
			// Target reference ticks per output tick, not one more
			if (EST_W'(nco_reg + 1'b1) >= target && in_reg != 3'h0)
			begin
				// Ratio of output ticks per input tick is 1, 2 or 4 [RULE4]
				emit = 1'b1;
				nco_next = '0;
				sub_next = sub_reg + 2'h1;
				if (sub_reg >= sub_last)
				begin
					sub_next = 2'h0;
					use_in = 1'b1;
				end
			end
		end
		in_next = in_reg;
		if (ci.mode != 2'h0 && ci.in_tick && in_reg != acg_pkg::FILL_MAX)
			in_next = in_next + 3'h1;
		if (use_in)
			in_next = in_next - 3'h1;
		out_next = out_reg;
		if (emit && out_reg != acg_pkg::FILL_MAX)
			out_next = out_next + 3'h1;
		if (ci.take && out_reg != 3'h0)
			out_next = out_next - 3'h1;
	end

	// State registers
	always_ff @(posedge clk_sys_i)
	begin
		if (srst_i)
		begin
			meas_reg <= '0;
			est_reg <= '0;
			nco_reg <= '0;
			sub_reg <= 2'h0;
			in_reg <= 3'h0;
			out_reg <= 3'h0;
		end
		else
		begin
			meas_reg <= meas_next;
			est_reg <= est_next;
			nco_reg <= nco_next;
			sub_reg <= sub_next;
			in_reg <= in_next;
			out_reg <= out_next;
		end
	end

	assign ci.in_fill = in_reg;
	assign ci.out_fill = out_reg;

	AST_FULL_STEP: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE8]
		ci.in_tick && ci.shift == 4'h0 |=> est_reg == $past(meas_reg))
		else $error("estimate did not take the full step at shift zero");
	AST_BYPASS: assert property (@(posedge clk_sys_i) disable iff (srst_i) // [RULE4]
		ci.mode == 2'h0 && ci.in_tick && !ci.take && out_reg < 3'h7
		|=> out_reg == $past(out_reg) + 3'h1)
		else $error("bypass tick did not reach the output fill");
endmodule

// >>> tb/acg_audio_partner.sv
// Far-side audio serial device: sources the pins while the block
// listens, and measures the block's clocks while the block drives.
// Assumes the block's pin outputs are registered on the system clock.
`timescale 1ns/1ns
module acg_audio_partner (
	input wire logic clk_i,
	input wire logic source_en_i,
	input wire logic dut_oe_i,
	input wire logic meas_bit_clk_i,
	input wire logic meas_word_sel_i,
	input wire logic meas_master_clk_i,
	output logic bit_clk_o,
	output logic word_sel_o,
	output logic [7:0] mclk_per_bit_o,
	output logic [7:0] bits_per_frame_o,
	output logic [15:0] frames_o
);
	logic [2:0] prev;
	logic [7:0] mcnt;
	logic [7:0] bcnt;
	logic [5:0] scnt;
	// Source only while the block listens; idle clock stands low
	initial
	begin
		bit_clk_o = 1'b0;
		word_sel_o = 1'b0;
		scnt = 6'h00;
		prev = 3'h0;
		mcnt = 8'h00;
		bcnt = 8'h00;
		frames_o = 16'h0000;
		forever
		begin
			#400;
			if (source_en_i && !dut_oe_i)
			begin
				bit_clk_o = ~bit_clk_o;
				scnt = bit_clk_o ? scnt : scnt + 6'h01;
				word_sel_o = (scnt == 6'h20) ? ~word_sel_o : word_sel_o;
				scnt = (scnt == 6'h20) ? 6'h00 : scnt;
			end
			else
			begin
				// Released word select wanders so no stale level is trusted
				bit_clk_o = 1'b0;
				word_sel_o = ~word_sel_o;
			end
		end
	end
	// Count master rises per bit period and bit rises per frame
	always @(posedge clk_i)
	begin
		if (meas_master_clk_i && !prev[0])
			mcnt = mcnt + 8'h01;
		if (meas_bit_clk_i && !prev[1])
		begin
			mclk_per_bit_o <= mcnt;
			mcnt = 8'h00;
			bcnt = bcnt + 8'h01;
		end
		if (meas_word_sel_i && !prev[2])
		begin
			bits_per_frame_o <= bcnt;
			bcnt = 8'h00;
			frames_o <= frames_o + 16'h0001;
		end
		prev = {meas_word_sel_i, meas_bit_clk_i, meas_master_clk_i};
	end
endmodule

// >>> tb/tb_audio_clock_generation.sv
// Self-checking bench for the audio clock generation block.
// Assumes the bus answers after one wait cycle and free-running sources.
`timescale 1ns/1ns
module tb_audio_clock_generation;
	logic clk = 1'b0, srst, rd, wr, vco = 1'b0, osc = 1'b0, src_en;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, q;
	logic [3:0] be;
	logic bclk_i, ws_i, bclk_o, bclk_oe, ws_o, ws_oe, mclk, p_bclk, p_ws;
	logic waitreq;
	logic [7:0] mpb, bpf;
	logic [15:0] frames;
	int miscompares = 0;
	int cmp_count = 0;
	int i, vco_cnt = 0, vco_mark = 0, vco_per_m = 0, mrises = 0;
	time t0;
	logic [7:0] ratio_tab [4] = '{8'h04, 8'h02, 8'h01, 8'h08};
	logic [19:0] n_tab [4] = '{20'h0_0000, 20'h1_0000, 20'h0_0100, 20'h0_0001};
	logic [23:0] cts_tab [4] = '{24'h00_0000, 24'h02_0000, 24'h00_0300,
		24'h00_0000};
	int vpm_tab [4] = '{2, 4, 6, 2};
	logic [7:0] cln_tab [5] = '{8'h1B, 8'h1D, 8'h1F, 8'h13, 8'h03};
	logic [3:0] sh_tab [5] = '{4'h0, 4'h1, 4'h0, 4'h2, 4'h0};
	time per_tab [5] = '{10560, 5280, 2640, 10560, 10560};
	// Clocks; VCO and oscillator run unrelated to the system clock
	always #20 clk = ~clk;
	always #165 vco = ~vco;
	always #125 osc = ~osc;
	// Pin wires resolve from whoever holds the enable
	assign bclk_i = bclk_oe ? bclk_o : p_bclk;
	assign ws_i = ws_oe ? ws_o : p_ws;
	always @(posedge vco)
		vco_cnt++;
	always @(posedge mclk)
	begin
		vco_per_m = vco_cnt - vco_mark;
		vco_mark = vco_cnt;
		mrises++;
	end
	acg_top dut_u (.clk_sys_i(clk), .srst_i(srst), .avs_address_i(addr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_byteenable_i(be), .avs_readdata_o(rdata),
		.avs_waitrequest_o(waitreq), .serial_pll_vco_clock_i(vco),
		.always_on_oscillator_i(osc), .bit_clk_i(bclk_i), .word_sel_i(ws_i),
		.bit_clk_o(bclk_o), .bit_clk_oe_o(bclk_oe), .word_sel_o(ws_o),
		.word_sel_oe_o(ws_oe), .master_clk_o(mclk));
	acg_audio_partner partner_u (.clk_i(clk), .source_en_i(src_en),
		.dut_oe_i(bclk_oe), .meas_bit_clk_i(bclk_o), .meas_word_sel_i(ws_o),
		.meas_master_clk_i(mclk), .bit_clk_o(p_bclk), .word_sel_o(p_ws),
		.mclk_per_bit_o(mpb), .bits_per_frame_o(bpf), .frames_o(frames));
	task automatic fail(input string msg);
		miscompares++;
		$display("wrong value at %0t: %s", $time, msg);
	endtask
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
			fail($sformatf("got %h expected %h", got, exp));
	endtask
	task automatic check_near(input time got, input time exp);
		cmp_count++;
		if (got * 5 < exp * 4 || got * 5 > exp * 6)
			fail($sformatf("period %0t expected near %0t", got, exp));
	endtask
	// One Avalon access; held until waitrequest is sampled low
	task automatic bus(input logic is_wr, input logic [5:0] idx,
		input logic [7:0] d, input logic [3:0] ben);
		int n;
		@(posedge clk);
		addr <= {idx, 2'h0};
		rd <= !is_wr;
		wr <= is_wr;
		wdata <= {24'h00_0000, d};
		be <= ben;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (waitreq !== 1'b0 && n < 50);
		q = rdata;
		if (n >= 50)
			fail("bus hang");
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic wr_reg(input logic [5:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d, 4'hF);
	endtask
	task automatic rd_check(input logic [5:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00, 4'hF);
		check_val(q, {24'h00_0000, e});
	endtask
	// Software writes every byte of N and CTS before relying on them
	task automatic prog(input logic [19:0] n, input logic [23:0] c,
		input logic [3:0] sh);
		wr_reg(acg_pkg::IDX_CTS0, c[7:0]);
		wr_reg(acg_pkg::IDX_CTS1, c[15:8]);
		wr_reg(acg_pkg::IDX_CTS2, c[23:16]);
		wr_reg(acg_pkg::IDX_N0, n[7:0]);
		wr_reg(acg_pkg::IDX_N1, n[15:8]);
		wr_reg(acg_pkg::IDX_N2_SHIFT, {sh, n[19:16]});
	endtask
	// Bounded wait for master clock rises (0) or frames (1)
	task automatic wait_ev(input logic which, input int n);
		int s;
		int k;
		s = which ? int'(frames) : mrises;
		k = 0;
		while ((which ? int'(frames) : mrises) - s < n && k < 20000)
		begin
			@(posedge clk);
			k++;
		end
		if (k >= 20000)
			fail("event wait expired");
	endtask
	task automatic end_of_test();
		$display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
		if (miscompares == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Watchdog sized well above the expected run of about 2 ms
	initial
	begin
		#4_000_000;
		fail("watchdog expired");
		end_of_test();
	end
	// Main sequence
	initial
	begin
		{srst, rd, wr, src_en, addr, wdata, be} = {4'h8, 8'h00, 36'h0_0000_0000};
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		for (i = 0; i < 8; i++)
			rd_check(6'h30 + i[5:0], 8'h00);
		check_val({27'h000_0000, bclk_o, ws_o, bclk_oe, ws_oe, mclk}, 32'h0000_0000);
		for (i = 0; i < 7; i++)
			wr_reg(6'h30 + i[5:0], 8'hA0 + i[7:0]);
		for (i = 0; i < 7; i++)
			rd_check(6'h30 + i[5:0], 8'hA0 + i[7:0]);
		wr_reg(acg_pkg::IDX_FIFO_STS, 8'hFF);
		bus(1'b0, acg_pkg::IDX_FIFO_STS, 8'h00, 4'hF);
		check_val(q & 32'hFFFF_FFC0, 32'h0000_0000);
		bus(1'b1, acg_pkg::IDX_CTS0, 8'h00, 4'hE);
		rd_check(acg_pkg::IDX_CTS0, 8'hA1);
		wr_reg(6'h38, 8'h55);
		rd_check(6'h38, 8'h00);
		for (i = 0; i < 7; i++)
			wr_reg(6'h30 + i[5:0], 8'h00);
		// Driving: bit clock ratio per code, 32 bit clocks per frame
		for (i = 0; i < 4; i++)
		begin
			// Stop the generators first so each ratio starts from a cleared master clock count
			wr_reg(acg_pkg::IDX_RATIO_CTRL, 8'h00);
			wr_reg(acg_pkg::IDX_RATIO_CTRL, {1'b1, i[1:0], 5'h01});
			wait_ev(1'b1, 3);
			check_val({24'h00_0000, mpb}, {24'h00_0000, ratio_tab[i]});
			check_val({24'h00_0000, bpf}, 32'h0000_0020);
			check_val({30'h0000_0000, bclk_oe, ws_oe}, 32'h0000_0003);
		end
		wr_reg(acg_pkg::IDX_RATIO_CTRL, 8'h00);
		wr_reg(acg_pkg::IDX_RATIO_CTRL, 8'h41);
		wait_ev(1'b1, 3);
		check_val({24'h00_0000, bpf}, 32'h0000_0040);
		// Regenerated rate in VCO edges per master clock period
		for (i = 0; i < 4; i++)
		begin
			prog(n_tab[i], cts_tab[i], 4'h0);
			wait_ev(1'b0, 4);
			check_val(32'(vco_per_m), 32'(vpm_tab[i]));
		end
		// Cleaned clock: reference choice, ratio and filter shift
		for (i = 0; i < 5; i++)
		begin
			prog(20'h0_0001, 24'h00_0010, sh_tab[i]);
			wr_reg(acg_pkg::IDX_RATIO_CTRL, cln_tab[i]);
			wait_ev(1'b0, 16);
			t0 = $time;
			wait_ev(1'b0, 4);
			check_near(($time - t0) / 4, per_tab[i]);
			bus(1'b0, acg_pkg::IDX_FIFO_STS, 8'h00, 4'hF);
			check_val(q & 32'hFFFF_FFC0, 32'h0000_0000);
		end
		// Listening: pins stay inputs and the block drives nothing
		wr_reg(acg_pkg::IDX_RATIO_CTRL, 8'h06);
		src_en <= 1'b1;
		for (i = 0; i < 10; i++)
		begin
			repeat (40) @(posedge clk);
			check_val({27'h000_0000, bclk_o, ws_o, bclk_oe, ws_oe, mclk}, 32'h0000_0000);
		end
		src_en <= 1'b0;
		end_of_test();
	end
endmodule
